// >>> logic/pgc_top.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
module pgc_top
(
  // clock and reset
  input  wire logic                 SYS_CLK,
  input  wire logic                 SRST,
  // axi4-lite write address and data
  input  wire logic [11:0]          S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [11:0]          S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  // generator events, same clock domain
  input  wire logic                 FAULT_EVENT,
  input  wire logic                 LIMIT_EVENT,
  input  wire logic                 TRIGGER_EVENT,
  input  wire logic                 CURRENT_LIMIT_MODE,
  // outputs to generator and interrupt controller
  output pgc_pkg::pgc_mode_type     MODE,
  output logic                      IRQ
);

  logic [15:0] ctrl;
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_hit;
  logic [15:0] wr_value;
  logic [15:0] next_ctrl;

  // address and data may arrive in either order; hold each until both
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // each ready only while its own channel holds nothing and no response outstanding
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID
                       && !do_write;
      S_AXI_WREADY  <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID
                       && !do_write;
    end
  end

  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  assign wr_hit   = do_write && (aw_addr[11:2] == pgc_pkg::CTRL_OFFSET[11:2]);

  // byte lanes merge into the 16-bit register; upper lanes have nothing
  always_comb
  begin
    wr_value = ctrl;
    if (w_strb[0])
      wr_value[7:0] = w_data[7:0];
    if (w_strb[1])
      wr_value[15:8] = w_data[15:8];
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= pgc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? pgc_pkg::RESP_OKAY : pgc_pkg::RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // control register next value
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_hit)
      next_ctrl = (ctrl & ~pgc_pkg::CTRL_WMASK) | (wr_value & pgc_pkg::CTRL_WMASK);
    // a zero enable clears its flag; an event in the same cycle only
    // sets the flag while its enable stays one, matching the clear rule
    if (next_ctrl[pgc_pkg::FAULT_EN] && FAULT_EVENT)
      next_ctrl[pgc_pkg::FAULT_PEND] = 1'b1;
    if (next_ctrl[pgc_pkg::LIMIT_EN] && LIMIT_EVENT)
      next_ctrl[pgc_pkg::LIMIT_PEND] = 1'b1;
    if (next_ctrl[pgc_pkg::TRIG_EN] && TRIGGER_EVENT)
      next_ctrl[pgc_pkg::TRIG_PEND] = 1'b1;
    if (!next_ctrl[pgc_pkg::FAULT_EN])
      next_ctrl[pgc_pkg::FAULT_PEND] = 1'b0;
    if (!next_ctrl[pgc_pkg::LIMIT_EN])
      next_ctrl[pgc_pkg::LIMIT_PEND] = 1'b0;
    if (!next_ctrl[pgc_pkg::TRIG_EN])
      next_ctrl[pgc_pkg::TRIG_PEND] = 1'b0;
    next_ctrl[4] = 1'b0;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      ctrl <= pgc_pkg::CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // read channel, one outstanding read
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= pgc_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      if (S_AXI_ARADDR[11:2] == pgc_pkg::CTRL_OFFSET[11:2])
      begin
        S_AXI_RDATA <= {16'h0000, ctrl};
        S_AXI_RRESP <= pgc_pkg::RESP_OKAY;
      end
      else
      begin
        S_AXI_RDATA <= 32'h00000000;
        S_AXI_RRESP <= pgc_pkg::RESP_SLVERR;
      end
    end
    else if (S_AXI_RVALID)
    begin
      if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
    else
      S_AXI_ARREADY <= 1'b1;
  end

  // effective modes; gated dependencies resolve here so the datapath
  // never sees a setting that has no meaning in the current mode
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      MODE <= '0;
    else
    begin
      MODE.period_from_phase <= next_ctrl[pgc_pkg::TIMEBASE_SEL];
      MODE.duty_from_master  <= next_ctrl[pgc_pkg::DUTY_SEL];
      MODE.dt_comp_polarity  <= next_ctrl[pgc_pkg::DT_POL]
        && (next_ctrl[pgc_pkg::DT_CTRL_HI:pgc_pkg::DT_CTRL_LO] == pgc_pkg::DT_COMP_CODE);
      MODE.center_aligned    <= next_ctrl[pgc_pkg::CENTER_MODE]
        && next_ctrl[pgc_pkg::TIMEBASE_SEL];
      MODE.ext_period_reset  <= next_ctrl[pgc_pkg::EXT_RESET]
        && next_ctrl[pgc_pkg::TIMEBASE_SEL] && !CURRENT_LIMIT_MODE;
      MODE.timebase_source   <= next_ctrl[pgc_pkg::MTB_SEL];
      MODE.immediate_update  <= next_ctrl[pgc_pkg::IMM_UPDATE];
    end
  end

  // request follows the flags; flags only exist while enabled
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      IRQ <= 1'b0;
    else
      IRQ <= (next_ctrl[pgc_pkg::FAULT_PEND] && next_ctrl[pgc_pkg::FAULT_EN])
          || (next_ctrl[pgc_pkg::LIMIT_PEND] && next_ctrl[pgc_pkg::LIMIT_EN])
          || (next_ctrl[pgc_pkg::TRIG_PEND] && next_ctrl[pgc_pkg::TRIG_EN]);
  end

endmodule // pgc_top

// >>> logic/pgc_pkg.sv
// What this block does
// - the fault pending flag is set by hardware on a fault event and cleared when its enable is written zero; the code sets it only while the fault enable is one.
// - the limit pending flag is set by hardware on a limit event and cleared when its enable is written zero; the code sets it only while the limit enable is one.
// - the trigger pending flag is set by hardware on a trigger event and cleared when its enable is written zero; the code sets it only while enabled.
// - a trigger event raises an interrupt request only while the trigger enable is one.
// - fault interrupt requests pass only while the fault enable is one.
// - limit interrupt requests pass only while the limit enable is one.
// - with the independent time base selected the period comes from the phase register, else from the master period.
// - with the duty source select set the master duty is used, else the generator's own duty.
// - the dead-time compensation polarity acts only while the dead-time field is binary 11.
// - center-aligned mode is ignored unless the independent time base is selected.
// - external period reset acts only with independent time base one and current-limit mode zero.
// - bit 4 reads zero and ignores writes; all implemented bits reset to zero.
package pgc_pkg;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_WMASK    = 16'h1FEF;
  localparam int          FAULT_PEND    = 15;
  localparam int          LIMIT_PEND    = 14;
  localparam int          TRIG_PEND     = 13;
  localparam int          FAULT_EN      = 12;
  localparam int          LIMIT_EN      = 11;
  localparam int          TRIG_EN       = 10;
  localparam int          TIMEBASE_SEL  = 9;
  localparam int          DUTY_SEL      = 8;
  localparam int          DT_CTRL_HI    = 7;
  localparam int          DT_CTRL_LO    = 6;
  localparam int          DT_POL        = 5;
  localparam int          MTB_SEL       = 3;
  localparam int          CENTER_MODE   = 2;
  localparam int          EXT_RESET     = 1;
  localparam int          IMM_UPDATE    = 0;
  localparam logic [1:0]  DT_COMP_CODE  = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // effective settings handed to the generator datapath
  typedef struct packed {
    logic period_from_phase;
    logic duty_from_master;
    logic dt_comp_polarity;
    logic center_aligned;
    logic ext_period_reset;
    logic timebase_source;
    logic immediate_update;
  } pgc_mode_type;
endpackage

// >>> tb/pgc_properties.sv
module pgc_properties
(
  // clock and reset
  input wire logic                  SYS_CLK,
  input wire logic                  SRST,
  // bus
  input wire logic                  S_AXI_WVALID,
  input wire logic                  S_AXI_ARVALID,
  input wire logic                  S_AXI_ARREADY,
  input wire logic                  S_AXI_RVALID,
  input wire logic [31:0]           S_AXI_RDATA,
  // events and outputs
  input wire logic                  FAULT_EVENT,
  input wire logic                  LIMIT_EVENT,
  input wire logic                  TRIGGER_EVENT,
  input wire logic                  CURRENT_LIMIT_MODE,
  input wire pgc_pkg::pgc_mode_type MODE,
  input wire logic                  IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // no event and no recent write: nothing may change the flags
  sequence s_quiet;
    !FAULT_EVENT && !LIMIT_EVENT && !TRIGGER_EVENT;
  endsequence
  sequence s_no_wr;
    !S_AXI_WVALID [*3];
  endsequence
  property p_rst_clear;
    $fell(SRST) |-> (MODE == 7'h00) && !IRQ;
  endproperty
  property p_irq_cause;
    (!IRQ ##0 s_quiet) |=> !IRQ;
  endproperty
  property p_flag_hold;
    (s_no_wr ##0 IRQ) |=> IRQ;
  endproperty
  property p_center;
    MODE.center_aligned |-> MODE.period_from_phase;
  endproperty
  property p_ext_tb;
    MODE.ext_period_reset |-> MODE.period_from_phase;
  endproperty
  // mode may lag the limit-mode input by one register stage
  property p_ext_clm;
    MODE.ext_period_reset && $stable(CURRENT_LIMIT_MODE) |-> !CURRENT_LIMIT_MODE;
  endproperty
  property p_rd_answer;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  property p_rd_zero;
    S_AXI_RVALID |-> (S_AXI_RDATA[31:16] == 16'h0000) && !S_AXI_RDATA[4];
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
  a_irq_cause: assert property (p_irq_cause) else $error("request without event");
  a_flag_hold: assert property (p_flag_hold) else $error("request dropped alone");
  a_center: assert property (p_center) else $error("center mode without timebase");
  a_ext_tb: assert property (p_ext_tb) else $error("period reset without timebase");
  a_ext_clm: assert property (p_ext_clm) else $error("period reset in limit mode");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_rd_zero: assert property (p_rd_zero) else $error("unused read bits set");
endmodule // pgc_properties

bind pgc_top pgc_properties chk_u (.*);

// >>> tb/pgc_top_test.sv
module pgc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk, rst, awv, wv, brd, arv, rrd, fe, le, te, clm;
  logic                  awr, wr, bv, arr, rv, irq;
  logic [11:0]           awa, ara;
  logic [31:0]           wd, rd, lf;
  logic [1:0]            br, rr;
  logic [15:0]           cm;
  pgc_pkg::pgc_mode_type md;
  int                    failures, compares;
  pgc_top dut_u (.SYS_CLK(clk), .SRST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd), .FAULT_EVENT(fe),
    .LIMIT_EVENT(le), .TRIGGER_EVENT(te), .CURRENT_LIMIT_MODE(clm), .MODE(md), .IRQ(irq));
  // expected generator settings from a control word
  function automatic pgc_pkg::pgc_mode_type mexp(logic [15:0] c, logic m);
    return {c[9], c[8], c[5] & (c[7:6] == 2'h3), c[2] & c[9], c[1] & c[9] & !m, c[3], c[0]};
  endfunction
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
    awa <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end
    while (!bv);
    brd <= 1'b0;
    chk({30'h0, br}, {30'h0, e});
    if (a == pgc_pkg::CTRL_OFFSET) cm = (d & pgc_pkg::CTRL_WMASK) | (cm & {d[12:10], 13'h0});
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    rrd <= 1'b0;
    chk(rd, e);
    chk({30'h0, rr}, {30'h0, r});
  endtask
  // one-cycle event pulse; only enabled sources may latch
  task automatic fire(input logic [2:0] ev);
    {fe, le, te} <= ev;
    @(posedge clk);
    {fe, le, te} <= 3'h0;
    cm[15:13] = cm[15:13] | (ev & cm[12:10]);
    @(posedge clk);
  endtask
  task automatic check_all();
    rd_reg(pgc_pkg::CTRL_OFFSET, {16'h0000, cm}, pgc_pkg::RESP_OKAY);
    chk({25'h0, md}, {25'h0, mexp(cm, clm)});
    chk({31'h0, irq}, {31'h0, |(cm[15:13] & cm[12:10])});
  endtask
  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    #200000;
    failures++;
    end_sim();
  end
  initial
  begin
    {rst, awv, wv, brd, arv, rrd, fe, le, te, clm} = 10'h200;
    {awa, ara, wd, cm} = 72'h0;
    lf = 32'h0166;
    failures = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_all();
    // corners first: all on, trigger enable dropped, all off; then random.
    // the module-on switch lives outside this block and stays off here, so
    // mode bits may still change between writes
    for (int i = 0; i < 40; i++)
    begin
      lf = nx(lf);
      clm <= lf[20];
      // a serviced flag is cleared by writing its enable to zero
      wr_reg(pgc_pkg::CTRL_OFFSET, i == 0 ? 16'hFFFF : i == 1 ? 16'h1800 : i == 2 ? 16'h0000
        : lf[15:0], pgc_pkg::RESP_OKAY);
      fire(i < 3 ? 3'h7 : lf[18:16]);
      check_all();
    end
    wr_reg(12'h004, 16'hFFFF, pgc_pkg::RESP_SLVERR);
    rd_reg(12'h004, 32'h0, pgc_pkg::RESP_SLVERR);
    check_all();
    end_sim();
  end
endmodule // pgc_top_test
